// ### bench/data_address_generator_test.sv
// Self-checking bench for the data address generator, APB master and op driver.
// Assumes the memory bus model and the design sources are compiled first.
`timescale 1ns/1ps
module data_address_generator_test;
  import dag_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [WORD_W-1:0] pwdata = '0, imm = '0, prdata, addr_out, seen_addr, rd;
  logic pready, pslverr, op_valid = 0, use_imm = 0, short_imm = 0, push = 0, intr = 0;
  logic addr_valid, addr_gen, seen_gen;
  op_kind_t kind = OP_POST;
  logic [PTR_W-1:0] isel = '0, msel = '0;
  word_size_t ws = WS_NORMAL, addr_ws, seen_ws;
  int seen_n, n_errors = 0, n_compared = 0;
  logic [WORD_W-1:0] ix[16] = '{default: '0}, md[16] = '{default: '0};
  logic [WORD_W-1:0] ln[16] = '{default: '0}, bs[16] = '{default: '0};
  logic [WORD_W-1:0] mode = '0, mask = '0, sticky = '0;
  logic [ADDR_W-1:0] rs[5] = '{IDX_OFS, BASE_OFS, MODE_OFS, MASK_OFS, STICKY_OFS};
  logic [ADDR_W-1:0] bad[2] = '{12'h200, 12'h046};

  data_address_generator i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_kind(kind), .op_index_sel(isel),
    .op_modify_sel(msel), .op_use_imm(use_imm), .op_short_imm(short_imm), .op_imm(imm),
    .op_word_size(ws), .push_status(push), .intr_entry(intr), .addr_out(addr_out),
    .addr_valid(addr_valid), .addr_gen(addr_gen), .addr_word_size(addr_ws));
  mem_bus_sink i_sink (.pclk(pclk), .presetn(presetn), .addr_valid(addr_valid),
    .addr_out(addr_out), .addr_gen(addr_gen), .addr_word_size(addr_ws),
    .seen_addr(seen_addr), .seen_gen(seen_gen), .seen_ws(seen_ws), .seen_n(seen_n));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_word(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] rev(logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] ra(logic [ADDR_W-1:0] o, logic [3:0] n);
    return o + {6'h0, n, 2'b00};
  endfunction

  task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_rd(string name, logic [ADDR_W-1:0] a, logic [31:0] exp);
    apb(1'b0, a, '0);
    check_word(name, exp, rd);
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    apb(1'b1, a, d);
    if (a == MODE_OFS) mode = d;
    else if (a == MASK_OFS) mask = d;
    else if (a == STICKY_OFS) sticky &= ~d;
    else if (a[7:6] == 2'd0) ix[a[5:2]] = d;
    else if (a[7:6] == 2'd1) md[a[5:2]] = d;
    else if (a[7:6] == 2'd2) ln[a[5:2]] = d;
    else begin
      bs[a[5:2]] = d;
      ix[a[5:2]] = d;
    end
  endtask

  task automatic op(op_kind_t k, logic [3:0] p, logic [3:0] m, logic ui, logic si,
                    logic [31:0] iv, word_size_t w);
    logic [31:0] mv, e, s;
    logic circ, wrp;
    int n0;
    mv = ui ? (si ? {{26{iv[5]}}, iv[5:0]} : iv) : md[{p[3], m[2:0]}];
    e = (k == OP_PRE) ? ix[p] + mv : ix[p];
    if ((p == 4'h0 && mode[1]) || (p == 4'h8 && mode[0])) e = rev(e);
    if (w == WS_LONG) e[0] = 1'b0;
    s = ix[p] + mv;
    circ = ln[p] != 0 && (k == OP_MODIFY || (k == OP_POST && mode[24]));
    wrp = circ && (mv[31] ? s < bs[p] : s >= bs[p] + ln[p]);
    if (wrp) s = mv[31] ? s + ln[p] : s - ln[p];
    if (wrp && p[2:0] == 3'h7) sticky[p[3]] = 1'b1;
    if (k == OP_BITREV) s = rev(s);
    if (k != OP_PRE) ix[p] = s;
    n0 = seen_n;
    @(posedge pclk);
    op_valid <= 1'b1;
    kind <= k;
    isel <= p;
    msel <= m;
    use_imm <= ui;
    short_imm <= si;
    imm <= iv;
    ws <= w;
    @(posedge pclk);
    op_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    if (k == OP_PRE || k == OP_POST) begin
      check_word("address", e, seen_addr);
      check_word("generator", {31'h0, p[3]}, {31'h0, seen_gen});
      check_word("word size", {30'h0, w}, {30'h0, seen_ws});
      check_word("address count", n0 + 1, seen_n);
    end else begin
      check_word("address count", n0, seen_n);
    end
    chk_rd("index", ra(IDX_OFS, p), ix[p]);
    chk_rd("sticky", STICKY_OFS, sticky);
  endtask

  task automatic pulse(logic ps, logic ie);
    @(posedge pclk);
    push <= ps;
    intr <= ie;
    @(posedge pclk);
    push <= 1'b0;
    intr <= 1'b0;
    if (mask[24]) mode[24] = 1'b0;
    chk_rd("mode", MODE_OFS, mode);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  initial begin
    logic [3:0] p, q;
    logic [31:0] b, l, m;
    void'($urandom(32'hbf73));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rs[i]) chk_rd("reset value", rs[i], '0);
    wr(ra(MODIFY_OFS, 1), 32'h5a5a_0001);
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hffff_ffff);
      check_word("write error", 1, {31'h0, err});
      apb(1'b0, bad[i], '0);
      check_word("read error", 1, {31'h0, err});
      check_word("refused read", '0, rd);
    end
    wr(ra(BASE_OFS, 3), 32'h0000_1003);
    chk_rd("base", ra(BASE_OFS, 3), 32'h0000_1003);
    wr(ra(MODIFY_OFS, 5), 32'h10);
    op(OP_PRE, 3, 5, 0, 0, 0, WS_NORMAL);
    op(OP_POST, 3, 13, 0, 0, 0, WS_NORMAL);
    op(OP_POST, 3, 0, 1, 0, 32'h4000_0000, WS_LONG);
    op(OP_PRE, 11, 0, 1, 1, 32'hffff_ff3f, WS_SHORT);
    wr(MODE_OFS, 32'h0100_0000);
    wr(ra(BASE_OFS, 7), 32'h100);
    wr(ra(LENGTH_OFS, 7), 32'h10);
    wr(ra(MODIFY_OFS, 2), 32'h6);
    repeat (3) op(OP_POST, 7, 2, 0, 0, 0, WS_NORMAL);
    op(OP_PRE, 7, 2, 0, 0, 0, WS_NORMAL);
    op(OP_POST, 7, 0, 1, 0, 32'hffff_fffa, WS_NORMAL);
    wr(STICKY_OFS, 32'h1);
    chk_rd("sticky", STICKY_OFS, sticky);
    wr(MODE_OFS, '0);
    wr(ra(BASE_OFS, 15), 32'h200);
    wr(ra(LENGTH_OFS, 15), 32'h8);
    repeat (2) op(OP_POST, 15, 0, 1, 0, 32'h5, WS_NORMAL);
    op(OP_MODIFY, 15, 0, 1, 0, 32'h5, WS_NORMAL);
    wr(MODE_OFS, 32'h2);
    wr(BASE_OFS, 32'h0008_a000);
    op(OP_POST, 0, 0, 1, 0, 32'h0400_0000, WS_NORMAL);
    check_word("reversed", 32'h0005_1000, seen_addr);
    op(OP_PRE, 0, 0, 1, 0, 0, WS_NORMAL);
    check_word("reversed", 32'h0005_1020, seen_addr);
    op(OP_BITREV, 4, 0, 1, 0, 32'h4, WS_NORMAL);
    wr(MODE_OFS, 32'h1);
    op(OP_PRE, 8, 0, 1, 0, 32'h1, WS_NORMAL);
    wr(MODE_OFS, 32'h0100_0000);
    pulse(1, 0);
    wr(MASK_OFS, 32'h0100_0000);
    pulse(1, 0);
    wr(MODE_OFS, 32'h0100_0000);
    pulse(0, 1);
    repeat (120) begin
      p = 4'($urandom_range(15));
      q = 4'($urandom_range(15));
      l = $urandom_range(40);
      b = ($urandom & 32'h0fff_fff0) | 32'h0000_0100;
      m = $urandom_range(l > 1 ? l - 1 : 7);
      if ($urandom_range(1) == 1) m = -m;
      // Base low and step below length, or up to 7 when length is 0 or 1, keep addresses in the map
      wr(MODE_OFS, {7'h0, 1'($urandom_range(1)), 24'h0});
      wr(ra(BASE_OFS, p), b);
      wr(ra(LENGTH_OFS, p), l);
      wr(ra(MODIFY_OFS, {p[3], q[2:0]}), m);
      repeat (3) op(op_kind_t'($urandom_range(2)), p, q, 1'($urandom_range(1)), 1'b0, m,
                    word_size_t'($urandom_range(2)));
    end
    summarize();
  end
endmodule

// ### bench/mem_bus_sink.sv
// Memory address bus model: records each address the generator presents.
// Assumes addr_valid is a one-cycle pulse per load or store, on pclk.
`timescale 1ns/1ps
module mem_bus_sink
  import dag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic addr_valid,
  input wire logic [WORD_W-1:0] addr_out,
  input wire logic addr_gen,
  input wire word_size_t addr_word_size,
  output logic [WORD_W-1:0] seen_addr,
  output logic seen_gen,
  output word_size_t seen_ws,
  output int seen_n
);
  // Memory uses the address as given, no realignment here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_addr <= '0;
      seen_gen <= 1'b0;
      seen_ws <= WS_NORMAL;
      seen_n <= 0;
    end else if (addr_valid) begin
      seen_addr <= addr_out;
      seen_gen <= addr_gen;
      seen_ws <= addr_word_size;
      seen_n <= seen_n + 1;
    end
  end
endmodule

// ### rtl/dag_modulo_unit.sv
// Adder and wrap logic for one index update.
// Assumes the caller has chosen index, modifier, base and length of one pointer.
`timescale 1ns/1ps
module dag_modulo_unit
  import dag_pkg::*;
(
  input wire logic [WORD_W-1:0] index_val,
  input wire logic [WORD_W-1:0] modifier,
  input wire logic [WORD_W-1:0] base_val,
  input wire logic [WORD_W-1:0] length_val,
  input wire logic circ_on,
  output logic [WORD_W-1:0] mod_sum,
  output logic [WORD_W-1:0] next_index,
  output logic wrapped
);

  logic [WORD_W-1:0] end_addr;

  always_comb begin
    mod_sum = index_val + modifier;
    end_addr = base_val + length_val;
    next_index = mod_sum;
    wrapped = 1'b0;
    // Plain unsigned compares; map overflow is left to software
    if (circ_on) begin
      if (!modifier[WORD_W-1] && (mod_sum >= end_addr)) begin
        next_index = mod_sum - length_val;
        wrapped = 1'b1;
      end else if (modifier[WORD_W-1] && (mod_sum < base_val)) begin
        next_index = mod_sum + length_val;
        wrapped = 1'b1;
      end
    end
  end

endmodule

// ### rtl/dag_pkg.sv
// Constants, types and helpers shared by the data address generator.
// Assumes a single core clock and an APB register port with 32-bit data.
// How it works
// - Pre-modify outputs index plus modifier, keeps index.
// - Post-modify outputs index, then writes index plus modifier.
// - Any modify register pairs with any same-generator index.
// - Single accesses take a full 32-bit immediate modifier.
// - Combined compute accesses take a 6-bit immediate.
// - Circular post-modify wraps the index back inside buffer.
// - Pre-modify never wraps; index stays unchanged.
// - Any base value is accepted, no alignment check.
// - Base write loads the matching index too.
// - Length, base, index of same number form one buffer.
// - Circular enable off means plain post-modify addressing.
// - Masked events clear circular enable automatically.
// - Overflow reporting only for pointers seven and fifteen.
// - Wrap on those pointers sets the sticky overflow flag.
// - Overflow flag stays set until software clears it.
// - Reverse mode outputs bit-reversed pointer zero address.
// - Bit-reverse instruction rewrites index plus modifier, reversed.
// - Output address is forced even for long-word accesses.
// - Index first decodes post-modify, modifier first pre-modify.
// - Wrap subtracts length going up, adds going down.
// - Zero length disables circular operation for that pointer.
// - Circular enable is bit 24 of the main mode register.
package dag_pkg;

  localparam int WORD_W = 32;
  localparam int NUM_PTR = 16;
  localparam int PTR_W = 4;
  localparam int SHORT_IMM_W = 6;
  localparam int ADDR_W = 12;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] IDX_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] MODIFY_OFS = 12'h040;
  localparam logic [ADDR_W-1:0] LENGTH_OFS = 12'h080;
  localparam logic [ADDR_W-1:0] BASE_OFS = 12'h0c0;
  localparam logic [ADDR_W-1:0] MODE_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] STICKY_OFS = 12'h108;

  // Field positions
  localparam int CIRC_EN_BIT = 24;
  localparam int REV_FIRST_BIT = 1;
  localparam int REV_SECOND_BIT = 0;
  localparam int OVF_FIRST_BIT = 0;
  localparam int OVF_SECOND_BIT = 1;

  localparam logic [WORD_W-1:0] MODE_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] STICKY_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] PTR_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] LONG_ALIGN_MASK = 32'hffff_fffe;

  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam logic [PTR_W-1:0] PTR_EIGHT = 4'h8;
  localparam logic [PTR_W-1:0] PTR_SEVEN = 4'h7;
  localparam logic [PTR_W-1:0] PTR_FIFTEEN = 4'hf;

  typedef enum logic [1:0] {OP_POST, OP_PRE, OP_MODIFY, OP_BITREV} op_kind_t;
  typedef enum logic [1:0] {WS_SHORT, WS_NORMAL, WS_LONG} word_size_t;

  function automatic logic [WORD_W-1:0] bit_reverse(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = v[WORD_W-1-i];
    end
    return r;
  endfunction

endpackage

// ### rtl/data_address_generator.sv
// Two data address generators sharing one operation port and an APB register file.
// Assumes the sequencer issues at most one operation per pclk on the same clock.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module data_address_generator
  import dag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WORD_W-1:0] pwdata,
  output logic [WORD_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire op_kind_t op_kind,
  input wire logic [PTR_W-1:0] op_index_sel,
  input wire logic [PTR_W-1:0] op_modify_sel,
  input wire logic op_use_imm,
  input wire logic op_short_imm,
  input wire logic [WORD_W-1:0] op_imm,
  input wire word_size_t op_word_size,
  input wire logic push_status,
  input wire logic intr_entry,
  output logic [WORD_W-1:0] addr_out,
  output logic addr_valid,
  output logic addr_gen,
  output word_size_t addr_word_size
);

  logic [WORD_W-1:0] index_reg [NUM_PTR];
  logic [WORD_W-1:0] index_next [NUM_PTR];
  logic [WORD_W-1:0] modify_reg [NUM_PTR];
  logic [WORD_W-1:0] modify_next [NUM_PTR];
  logic [WORD_W-1:0] length_reg [NUM_PTR];
  logic [WORD_W-1:0] length_next [NUM_PTR];
  logic [WORD_W-1:0] base_reg [NUM_PTR];
  logic [WORD_W-1:0] base_next [NUM_PTR];
  logic [WORD_W-1:0] main_mode_register_reg;
  logic [WORD_W-1:0] main_mode_register_next;
  logic [WORD_W-1:0] mode_mask_register_reg;
  logic [WORD_W-1:0] mode_mask_register_next;
  logic [WORD_W-1:0] sticky_status_register_reg;
  logic [WORD_W-1:0] sticky_status_register_next;
  logic [WORD_W-1:0] prdata_reg;
  logic [WORD_W-1:0] prdata_next;
  logic [WORD_W-1:0] addr_out_reg;
  logic [WORD_W-1:0] addr_out_next;
  logic addr_valid_reg;
  logic addr_valid_next;
  logic addr_gen_reg;
  logic addr_gen_next;
  word_size_t addr_word_size_reg;
  word_size_t addr_word_size_next;

  logic [PTR_W-1:0] msel;
  logic [WORD_W-1:0] idx_val;
  logic [WORD_W-1:0] mod_val;
  logic [WORD_W-1:0] mod_sum;
  logic [WORD_W-1:0] wrap_index;
  logic wrapped;
  logic circ_wrap_enable;
  logic circ_on;
  logic reverse_out;
  logic [WORD_W-1:0] raw_addr;
  logic [WORD_W-1:0] shaped_addr;
  logic ovf_event_first;
  logic ovf_event_second;
  logic [WORD_W-1:0] sticky_set;
  logic wr_en;
  logic rd_setup;
  logic [PTR_W-1:0] reg_sel;
  logic addr_ok;

  // Map decode shared by read and write paths
  function automatic logic map_hit(input logic [ADDR_W-1:0] a);
    logic grp_ok;
    logic misc_ok;
    grp_ok = (a[ADDR_W-1:6] == IDX_OFS[ADDR_W-1:6]) ||
             (a[ADDR_W-1:6] == MODIFY_OFS[ADDR_W-1:6]) ||
             (a[ADDR_W-1:6] == LENGTH_OFS[ADDR_W-1:6]) ||
             (a[ADDR_W-1:6] == BASE_OFS[ADDR_W-1:6]);
    misc_ok = (a == MODE_OFS) || (a == MASK_OFS) || (a == STICKY_OFS);
    return (a[1:0] == 2'h0) && (grp_ok || misc_ok);
  endfunction

  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign reg_sel = paddr[5:2];
  assign addr_ok = map_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_reg;
  assign addr_out = addr_out_reg;
  assign addr_valid = addr_valid_reg;
  assign addr_gen = addr_gen_reg;
  assign addr_word_size = addr_word_size_reg;

  // Modifier always comes from the index's own generator half
  assign msel = {op_index_sel[PTR_W-1], op_modify_sel[PTR_W-2:0]};
  assign idx_val = index_reg[op_index_sel];
  assign circ_wrap_enable = main_mode_register_reg[CIRC_EN_BIT];

  always_comb begin
    if (!op_use_imm) begin
      mod_val = modify_reg[msel];
    end else if (op_short_imm) begin
      mod_val = {{(WORD_W-SHORT_IMM_W){op_imm[SHORT_IMM_W-1]}}, op_imm[SHORT_IMM_W-1:0]};
    end else begin
      mod_val = op_imm;
    end
  end

  // Modify instruction wraps regardless of the enable bit; post-modify accesses need it, pre-modify never wraps
  always_comb begin
    circ_on = 1'b0;
    if (length_reg[op_index_sel] != '0) begin
      if (op_kind == OP_MODIFY) begin
        circ_on = 1'b1;
      end else if (op_kind == OP_POST) begin
        circ_on = circ_wrap_enable;
      end
    end
  end

  dag_modulo_unit u_modulo (
    .index_val(idx_val),
    .modifier(mod_val),
    .base_val(base_reg[op_index_sel]),
    .length_val(length_reg[op_index_sel]),
    .circ_on(circ_on),
    .mod_sum(mod_sum),
    .next_index(wrap_index),
    .wrapped(wrapped)
  );

  assign reverse_out = ((op_index_sel == PTR_ZERO) && main_mode_register_reg[REV_FIRST_BIT]) ||
                       ((op_index_sel == PTR_EIGHT) && main_mode_register_reg[REV_SECOND_BIT]);

  always_comb begin
    raw_addr = (op_kind == OP_PRE) ? mod_sum : idx_val;
    if (reverse_out) begin
      raw_addr = bit_reverse(raw_addr);
    end
    // Long words occupy two normal slots, so the low bit is dropped
    shaped_addr = (op_word_size == WS_LONG) ? (raw_addr & LONG_ALIGN_MASK) : raw_addr;
  end

  assign ovf_event_first = op_valid && wrapped && (op_index_sel == PTR_SEVEN);
  assign ovf_event_second = op_valid && wrapped && (op_index_sel == PTR_FIFTEEN);

  always_comb begin
    sticky_set = '0;
    sticky_set[OVF_FIRST_BIT] = ovf_event_first;
    sticky_set[OVF_SECOND_BIT] = ovf_event_second;
  end

  // Pointer, mode and status next values
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      index_next[i] = index_reg[i];
      modify_next[i] = modify_reg[i];
      length_next[i] = length_reg[i];
      base_next[i] = base_reg[i];
    end
    main_mode_register_next = main_mode_register_reg;
    mode_mask_register_next = mode_mask_register_reg;
    sticky_status_register_next = sticky_status_register_reg;

    if (op_valid) begin
      unique case (op_kind)
        OP_POST: index_next[op_index_sel] = wrap_index;
        OP_PRE: index_next[op_index_sel] = idx_val;
        OP_MODIFY: index_next[op_index_sel] = wrap_index;
        OP_BITREV: index_next[op_index_sel] = bit_reverse(mod_sum);
      endcase
    end

    // A bus write to the same pointer lands after the operation's update
    if (wr_en) begin
      if (paddr[ADDR_W-1:6] == IDX_OFS[ADDR_W-1:6]) begin
        index_next[reg_sel] = pwdata;
      end else if (paddr[ADDR_W-1:6] == MODIFY_OFS[ADDR_W-1:6]) begin
        modify_next[reg_sel] = pwdata;
      end else if (paddr[ADDR_W-1:6] == LENGTH_OFS[ADDR_W-1:6]) begin
        length_next[reg_sel] = pwdata;
      end else if (paddr[ADDR_W-1:6] == BASE_OFS[ADDR_W-1:6]) begin
        base_next[reg_sel] = pwdata;
        index_next[reg_sel] = pwdata;
      end else if (paddr == MODE_OFS) begin
        main_mode_register_next = pwdata;
      end else if (paddr == MASK_OFS) begin
        mode_mask_register_next = pwdata;
      end else begin
        sticky_status_register_next = sticky_status_register_reg & ~pwdata;
      end
    end

    // New wraps win over a write-one clear in the same cycle
    sticky_status_register_next = sticky_status_register_next | sticky_set;

    if ((push_status || intr_entry) && mode_mask_register_reg[CIRC_EN_BIT]) begin
      main_mode_register_next[CIRC_EN_BIT] = 1'b0;
    end
  end

  // Read data and address outputs
  always_comb begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      prdata_next = '0;
      // Refused reads must not leak a group register through the low bits
      if (!addr_ok) begin
        prdata_next = '0;
      end else if (paddr[ADDR_W-1:6] == IDX_OFS[ADDR_W-1:6]) begin
        prdata_next = index_reg[reg_sel];
      end else if (paddr[ADDR_W-1:6] == MODIFY_OFS[ADDR_W-1:6]) begin
        prdata_next = modify_reg[reg_sel];
      end else if (paddr[ADDR_W-1:6] == LENGTH_OFS[ADDR_W-1:6]) begin
        prdata_next = length_reg[reg_sel];
      end else if (paddr[ADDR_W-1:6] == BASE_OFS[ADDR_W-1:6]) begin
        prdata_next = base_reg[reg_sel];
      end else if (paddr == MODE_OFS) begin
        prdata_next = main_mode_register_reg;
      end else if (paddr == MASK_OFS) begin
        prdata_next = mode_mask_register_reg;
      end else if (paddr == STICKY_OFS) begin
        prdata_next = sticky_status_register_reg;
      end
    end
    addr_valid_next = op_valid && ((op_kind == OP_POST) || (op_kind == OP_PRE));
    addr_out_next = addr_out_reg;
    addr_gen_next = addr_gen_reg;
    addr_word_size_next = addr_word_size_reg;
    if (addr_valid_next) begin
      addr_out_next = shaped_addr;
      addr_gen_next = op_index_sel[PTR_W-1];
      addr_word_size_next = op_word_size;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        index_reg[i] <= PTR_RESET;
        modify_reg[i] <= PTR_RESET;
        length_reg[i] <= PTR_RESET;
        base_reg[i] <= PTR_RESET;
      end
      main_mode_register_reg <= MODE_RESET;
      mode_mask_register_reg <= MASK_RESET;
      sticky_status_register_reg <= STICKY_RESET;
    end else begin
      for (int i = 0; i < NUM_PTR; i++) begin
        index_reg[i] <= index_next[i];
        modify_reg[i] <= modify_next[i];
        length_reg[i] <= length_next[i];
        base_reg[i] <= base_next[i];
      end
      main_mode_register_reg <= main_mode_register_next;
      mode_mask_register_reg <= mode_mask_register_next;
      sticky_status_register_reg <= sticky_status_register_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      addr_out_reg <= '0;
      addr_valid_reg <= 1'b0;
      addr_gen_reg <= 1'b0;
      addr_word_size_reg <= WS_NORMAL;
    end else begin
      prdata_reg <= prdata_next;
      addr_out_reg <= addr_out_next;
      addr_valid_reg <= addr_valid_next;
      addr_gen_reg <= addr_gen_next;
      addr_word_size_reg <= addr_word_size_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pre_addr_sum_a: assert property (
    op_valid && op_kind == OP_PRE && !reverse_out && op_word_size == WS_NORMAL
    |=> addr_valid && addr_out == $past(idx_val + mod_val))
    else $error("pre-modify address is not index plus modifier");

  pre_keeps_index_a: assert property (
    op_valid && op_kind == OP_PRE && !wr_en
    |=> index_reg[$past(op_index_sel)] == $past(idx_val))
    else $error("pre-modify changed the index");

  post_addr_a: assert property (
    op_valid && op_kind == OP_POST && !reverse_out && op_word_size == WS_NORMAL
    |=> addr_valid && addr_out == $past(idx_val))
    else $error("post-modify address is not the old index");

  circ_off_plain_a: assert property (
    op_valid && op_kind == OP_POST && !circ_wrap_enable && !wr_en
    |=> index_reg[$past(op_index_sel)] == $past(idx_val + mod_val))
    else $error("post-modify wrapped with circular buffering off");

  length_zero_a: assert property (
    op_valid && op_kind == OP_MODIFY && length_reg[op_index_sel] == '0 && !wr_en
    |=> index_reg[$past(op_index_sel)] == $past(idx_val + mod_val))
    else $error("zero length pointer wrapped");

  short_imm_a: assert property (
    op_use_imm && op_short_imm
    |-> mod_val[SHORT_IMM_W-1:0] == op_imm[SHORT_IMM_W-1:0] &&
        (&mod_val[WORD_W-1:SHORT_IMM_W-1] || !(|mod_val[WORD_W-1:SHORT_IMM_W-1])))
    else $error("short immediate not limited to six bits");

  base_load_a: assert property (
    wr_en && paddr[ADDR_W-1:6] == BASE_OFS[ADDR_W-1:6]
    |=> index_reg[$past(reg_sel)] == $past(pwdata) && base_reg[$past(reg_sel)] == $past(pwdata))
    else $error("base write did not load the index");

  wrap_sets_flag_a: assert property (
    ovf_event_first |=> sticky_status_register_reg[OVF_FIRST_BIT] ##1
    (sticky_status_register_reg[OVF_FIRST_BIT] || $past(wr_en)))
    else $error("wrap on pointer seven not flagged");

  sticky_hold_a: assert property (
    sticky_status_register_reg[OVF_SECOND_BIT] && !(wr_en && paddr == STICKY_OFS)
    |=> sticky_status_register_reg[OVF_SECOND_BIT])
    else $error("overflow flag dropped without a clear");

  auto_clear_a: assert property (
    (push_status || intr_entry) && mode_mask_register_reg[CIRC_EN_BIT]
    |=> !main_mode_register_reg[CIRC_EN_BIT])
    else $error("circular enable not cleared on masked event");

  bitrev_op_a: assert property (
    op_valid && op_kind == OP_BITREV && !wr_en
    |=> index_reg[$past(op_index_sel)] == bit_reverse($past(mod_sum)) && !addr_valid)
    else $error("bit-reverse instruction result wrong");

  rev_out_a: assert property (
    op_valid && op_kind == OP_POST && op_index_sel == PTR_ZERO &&
    main_mode_register_reg[REV_FIRST_BIT] && op_word_size == WS_NORMAL
    |=> addr_out == bit_reverse($past(idx_val)))
    else $error("reversed output address wrong");

endmodule
